// *** signalling_extractor_regs.vh ***
// Constants for the signalling extractor indirect access block
// How it works
// R1: Writing a valid index and operation to address/control starts one internal access.
// R2: Bit 7 of address/control selects internal read at 1, write at 0.
// R3: Index sits in bits 5..0; bit 6 unused; used bits reset to zero.
// R4: Data buffer holds a nibble: write data, or read result after completion.
// R5: Host loads the data nibble before writing index with write operation.
// R6: Read request returns the addressed nibble into the buffer within 640 ns.
// R7: Top index bit selects channel configuration at 1, signalling data at 0.
// R8: Indices 01h-18h are channel 1-24 signalling; 19h-1Fh are ignored.
// R9: Index 20h is extractor configuration; 21h-38h channel configuration; rest ignored.
// R10: Signalling read returns A, B, C, D in bits 3..0, upper bits zero.
// R11: In twelve-frame superframe formats returned C equals A and D equals B.
// R12: Returned signalling is the state from the third most recent superframe.
// R13: With debounce, state changes only after two consecutive equal superframes.
// R14: Channel configuration bit 0 enables debounce for that channel.
// R15: Channel configuration bit 3 inverts channel data; framing bits pass unchanged.
// R16: Channel configuration bit 2 forces the channel byte LSB to the level bit.
// R17: Bit 1 sets the forced level; inverted when inversion is also enabled.
// R18: Busy flag stays high during an internal access and drops on completion.
// R19: Per-channel inversion, fixing and debounce act only while function enable is set.
// R20: Host must set indirect access enable; it resets to zero.
// R21: Unused bits read as zero and writes to them are discarded.
`ifndef SIG_EXTRACT_REGS_VH
`define SIG_EXTRACT_REGS_VH

`define ADDR_EXTR_CONFIG  8'h40
`define ADDR_ACCESS_STAT  8'h41
`define ADDR_IND_ADDR_CTL 8'h42
`define ADDR_IND_DATA_BUF 8'h43

`define CFG_FUNC_EN_BIT     0
`define CFG_INDIRECT_EN_BIT 1
`define CFG_FMS0_BIT 2
`define CFG_FMS1_BIT 3
`define CFG_ESF_BIT  4
`define CFG_RESET    5'h00

`define ACTL_RNW_BIT 7
`define ACTL_RESET   7'h00
`define DBUF_RESET   4'h0
`define STAT_BUSY_BIT 7

`define CH_DEBOUNCE_BIT 0
`define CH_LEVEL_BIT    1
`define CH_FIX_BIT      2
`define CH_INVERT_BIT   3
`define CH_CFG_RESET 4'h0
`define SIG_RESET    4'h0

`define NUM_CHAN     24
`define IDX_CH_LAST  5'h18
`define IDX_EXTR_CFG 6'h20

`define CLK_PERIOD_NS 10
`define ACCESS_MAX_NS 640
`define ACCESS_MAX_CYC (`ACCESS_MAX_NS / `CLK_PERIOD_NS)
`define ACCESS_LAT_CYC 4'h4

`endif

// *** signalling_indirect_access.v ***
// Indirect access path and receive per-channel processing of the signalling extractor
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "signalling_extractor_regs.vh"

module signalling_indirect_access
(
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       pcm_valid_i,
  input  wire [7:0] pcm_data_i,
  input  wire       pcm_fbit_i,
  input  wire [4:0] pcm_chan_i,
  output reg        pcm_valid_o,
  output reg  [7:0] pcm_data_o,
  output reg        pcm_fbit_o,
  input  wire       sig_upd_i,
  input  wire [4:0] sig_chan_i,
  input  wire [3:0] sig_abcd_i
);

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  // Last count of a fixed-length access
  localparam [3:0] CNT_LAST = `ACCESS_LAT_CYC - 4'h1;

  reg  [4:0] extr_cfg_reg;
  reg        rnw_reg;
  reg  [5:0] idx_reg;
  reg  [3:0] dbuf_reg;
  reg        state_reg;
  reg  [3:0] cnt_reg;

  wire       esf_w;
  wire       fms0_w;
  wire       func_en_w;
  wire       indirect_en_w;
  wire       sig_off_w;
  wire       busy_w;

  wire       wr_cfg_w;
  wire       wr_actl_w;
  wire       wr_dbuf_w;
  wire       idx_sig_ok_w;
  wire       idx_cfg_ok_w;
  wire [5:0] req_idx_w;
  wire       req_ok_w;
  wire       start_w;
  wire       done_w;
  wire       acc_wr_w;
  wire       acc_rd_w;
  wire [4:0] acc_ch_w;
  wire       acc_ch_ok_w;
  wire       acc_ch_wr_w;
  wire       acc_ext_wr_w;

  wire [3:0] ch_cfg_w [1:`NUM_CHAN];
  wire [3:0] ch_sig_w [1:`NUM_CHAN];

  reg  [3:0] rd_nib;
  reg  [3:0] sig_view;
  reg  [7:0] rd_mux;
  reg  [3:0] pcm_cfg;
  reg  [7:0] pcm_proc;
  reg        invert_en;
  reg        fix_en;

  assign esf_w  = extr_cfg_reg[`CFG_ESF_BIT];
  assign fms0_w = extr_cfg_reg[`CFG_FMS0_BIT];
  assign func_en_w     = extr_cfg_reg[`CFG_FUNC_EN_BIT];
  assign indirect_en_w = extr_cfg_reg[`CFG_INDIRECT_EN_BIT];
  // Extraction and fixing off in non-ESF mode with FMS0 set
  assign sig_off_w = ~esf_w & fms0_w;
  // R18: busy while access runs
  assign busy_w = (state_reg == ST_BUSY);

  assign wr_cfg_w  = wr_i & (addr_i == `ADDR_EXTR_CONFIG);
  assign wr_actl_w = wr_i & (addr_i == `ADDR_IND_ADDR_CTL);
  assign wr_dbuf_w = wr_i & (addr_i == `ADDR_IND_DATA_BUF);

  assign req_idx_w = wdata_i[5:0];
  // R8: signalling indices 01h-18h only
  assign idx_sig_ok_w = ~req_idx_w[5] & (req_idx_w[4:0] != 5'h00)
                        & (req_idx_w[4:0] <= `IDX_CH_LAST);
  // R9: 20h plus 21h-38h only
  assign idx_cfg_ok_w = req_idx_w[5] & (req_idx_w[4:0] <= `IDX_CH_LAST);
  // R2: signalling data cannot be written
  assign req_ok_w = idx_cfg_ok_w | (idx_sig_ok_w & wdata_i[`ACTL_RNW_BIT]);
  // R1: valid write starts one access
  assign start_w = wr_actl_w & ~busy_w & indirect_en_w & req_ok_w;

  assign done_w   = busy_w & (cnt_reg == CNT_LAST);
  assign acc_wr_w = done_w & ~rnw_reg;
  assign acc_rd_w = done_w & rnw_reg;
  assign acc_ch_w = idx_reg[4:0];
  assign acc_ch_ok_w  = (acc_ch_w != 5'h00);
  // R7: top index bit picks configuration
  assign acc_ch_wr_w  = acc_wr_w & idx_reg[5] & acc_ch_ok_w;
  assign acc_ext_wr_w = acc_wr_w & (idx_reg == `IDX_EXTR_CFG);

  // Extractor configuration
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      extr_cfg_reg <= `CFG_RESET;
    end
    // Internal write keeps the format bit
    else if (acc_ext_wr_w)
    begin
      extr_cfg_reg[3:0] <= dbuf_reg;
    end
    // R20: enable bit reset low, set by host
    else if (wr_cfg_w)
    begin
      extr_cfg_reg <= wdata_i[4:0];
    end
  end

  // Address/control register
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rnw_reg <= 1'b0;
      idx_reg <= 6'h00;
    end
    // Writes during a running access dropped whole
    // R3: index in 5..0, bit 6 dropped
    else if (wr_actl_w & ~busy_w)
    begin
      rnw_reg <= wdata_i[`ACTL_RNW_BIT];
      idx_reg <= req_idx_w;
    end
  end

  // Access sequencer
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // Counter parked at zero while idle
          cnt_reg <= 4'h0;
          if (start_w)
          begin
            state_reg <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          // R6: completes well inside the bound
          if (done_w)
          begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
          end
          else
          begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          cnt_reg   <= 4'h0;
        end
      endcase
    end
  end

  // R4: data buffer, read result wins over host write
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dbuf_reg <= `DBUF_RESET;
    end
    else if (acc_rd_w)
    begin
      dbuf_reg <= rd_nib;
    end
    // R5: host loads write nibble first
    else if (wr_dbuf_w)
    begin
      dbuf_reg <= wdata_i[3:0];
    end
  end

  // Per-channel configuration and signalling history
  genvar gi;
  generate
    for (gi = 1; gi <= `NUM_CHAN; gi = gi + 1)
    begin : chan
      reg  [3:0] cfg_reg;
      reg  [3:0] sf1_reg;
      reg  [3:0] sf2_reg;
      reg  [3:0] sf3_reg;
      wire       debounce_w;
      wire       upd_w;
      // Channel number at channel field width
      localparam [4:0] CH_NUM = gi;

      // R14: bit 0 enables debounce
      // R19: gated by function enable
      assign debounce_w = func_en_w & cfg_reg[`CH_DEBOUNCE_BIT];
      assign upd_w      = sig_upd_i & (sig_chan_i == CH_NUM);

      always @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          cfg_reg <= `CH_CFG_RESET;
        end
        // R9: 21h-38h map to channels
        else if (acc_ch_wr_w & (acc_ch_w == CH_NUM))
        begin
          cfg_reg <= dbuf_reg;
        end
      end

      always @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          sf1_reg <= `SIG_RESET;
          sf2_reg <= `SIG_RESET;
          sf3_reg <= `SIG_RESET;
        end
        else if (upd_w)
        begin
          // R12: three superframes deep
          sf1_reg <= sig_abcd_i;
          sf2_reg <= sf1_reg;
          // R13: accept only two equal superframes
          if (~debounce_w | (sf1_reg == sf2_reg))
          begin
            sf3_reg <= sf2_reg;
          end
        end
      end

      assign ch_cfg_w[gi] = cfg_reg;
      assign ch_sig_w[gi] = sf3_reg;
    end
  endgenerate

  // Internal read value
  always @*
  begin
    sig_view = 4'h0;
    rd_nib   = 4'h0;
    // Ignored indices read as zero
    if (acc_ch_ok_w & (acc_ch_w <= `IDX_CH_LAST))
    begin
      sig_view = ch_sig_w[acc_ch_w];
    end
    // R11: C=A and D=B outside ESF
    if (~esf_w)
    begin
      sig_view = {sig_view[3], sig_view[2], sig_view[3], sig_view[2]};
    end
    if (sig_off_w)
    begin
      sig_view = 4'h0;
    end
    if (idx_reg[5])
    begin
      if (idx_reg == `IDX_EXTR_CFG)
      begin
        rd_nib = extr_cfg_reg[3:0];
      end
      else if (acc_ch_ok_w & (acc_ch_w <= `IDX_CH_LAST))
      begin
        rd_nib = ch_cfg_w[acc_ch_w];
      end
    end
    else
    begin
      // R10: A,B,C,D in bits 3..0
      rd_nib = sig_view;
    end
  end

  // Host register read
  always @*
  begin
    rd_mux = 8'h00;
    // R21: unused bits read zero
    case (addr_i)
      `ADDR_EXTR_CONFIG:  rd_mux = {3'h0, extr_cfg_reg};
      `ADDR_ACCESS_STAT:  rd_mux = {busy_w, 7'h00};
      `ADDR_IND_ADDR_CTL: rd_mux = {rnw_reg, 1'b0, idx_reg};
      `ADDR_IND_DATA_BUF: rd_mux = {4'h0, dbuf_reg};
      default:            rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_i)
    begin
      rdata_o <= rd_mux;
    end
    // Read data stands for one cycle only
    else
    begin
      rdata_o <= 8'h00;
    end
  end

  // Receive PCM processing
  always @*
  begin
    pcm_cfg   = 4'h0;
    pcm_proc  = pcm_data_i;
    invert_en = 1'b0;
    fix_en    = 1'b0;
    if ((pcm_chan_i != 5'h00) & (pcm_chan_i <= `IDX_CH_LAST))
    begin
      pcm_cfg = ch_cfg_w[pcm_chan_i];
    end
    // R15: inversion skips framing bits
    // R19: only with function enable
    invert_en = func_en_w & pcm_cfg[`CH_INVERT_BIT] & ~pcm_fbit_i;
    // R16: fix LSB when enabled
    fix_en = func_en_w & pcm_cfg[`CH_FIX_BIT] & ~pcm_fbit_i & ~sig_off_w;
    if (invert_en)
    begin
      pcm_proc = ~pcm_data_i;
    end
    if (fix_en)
    begin
      // R17: level flips under inversion
      pcm_proc[0] = pcm_cfg[`CH_LEVEL_BIT] ^ invert_en;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pcm_valid_o <= 1'b0;
      pcm_data_o  <= 8'h00;
      pcm_fbit_o  <= 1'b0;
    end
    else
    begin
      pcm_valid_o <= pcm_valid_i;
      // Data holds between valid bytes
      if (pcm_valid_i)
      begin
        pcm_data_o <= pcm_proc;
        pcm_fbit_o <= pcm_fbit_i;
      end
    end
  end

endmodule

// *** sia_monitor.sv ***
// Port checker for the indirect access block
`timescale 1ns/1ps
module sia_monitor
(
  input wire       clk_i,
  input wire       sys_rst_i,
  input wire [7:0] addr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       pcm_valid_i,
  input wire [7:0] pcm_data_i,
  input wire       pcm_fbit_i,
  input wire       pcm_valid_o,
  input wire [7:0] pcm_data_o,
  input wire       pcm_fbit_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata not idle");
  unmapped_read_a: assert property (rd_i && addr_i > 8'h43 |=> rdata_o == 8'h00)
    else $error("unmapped read");
  ctl_spare_a: assert property (rd_i && addr_i == 8'h42 |=> !rdata_o[6])
    else $error("ctl bit 6 set");
  buf_upper_a: assert property (rd_i && addr_i == 8'h43 |=> rdata_o[7:4] == 4'h0)
    else $error("buffer upper set");
  stat_spare_a: assert property (rd_i && addr_i == 8'h41 |=> rdata_o[6:0] == 7'h00)
    else $error("status spare set");
  fbit_pass_a: assert property (pcm_valid_i && pcm_fbit_i
    |=> pcm_fbit_o && pcm_data_o == $past(pcm_data_i))
    else $error("framing byte altered");
  byte_out_a: assert property (pcm_valid_i |=> pcm_valid_o)
    else $error("byte lost");
  hold_out_a: assert property (!pcm_valid_i |=> !pcm_valid_o && $stable(pcm_data_o))
    else $error("output moved");
  cover property (rd_i && addr_i == 8'h41 ##1 rdata_o[7]);
  cover property (pcm_valid_i && pcm_fbit_i);
  cover property (rd_i && addr_i == 8'h43);
endmodule

bind signalling_indirect_access sia_monitor MON
(
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pcm_valid_i(pcm_valid_i), .pcm_data_i(pcm_data_i),
  .pcm_fbit_i(pcm_fbit_i), .pcm_valid_o(pcm_valid_o),
  .pcm_data_o(pcm_data_o), .pcm_fbit_o(pcm_fbit_o)
);

// *** host_model.sv ***
// Host bus master model for register accesses
`timescale 1ns/1ps
module host_model
(
  input  wire       clk_i,
  input  wire [7:0] rdata_i,
  output reg  [7:0] addr_o,
  output reg  [7:0] wdata_o,
  output reg        wr_o,
  output reg        rd_o
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  end
  endtask
  task indirect(input [7:0] c, input [3:0] w, output [7:0] s0, output [7:0] s1,
           output [7:0] dv);
    integer n;
  begin
    if (!c[7])
      wr(8'h43, {4'h0, w});
    wr(8'h42, c);
    rd(8'h41, s0);
    s1 = s0;
    n = 0;
    while (s1[7] && n < 32)
    begin
      rd(8'h41, s1);
      n = n + 1;
    end
    rd(8'h43, dv);
  end
  endtask
endmodule

// *** signalling_indirect_access_bench.sv ***
// Self-checking bench for the indirect access block
`timescale 1ns/1ps
module signalling_indirect_access_bench;
  reg        clk_i;
  reg        sys_rst_i;
  reg        pcm_valid_i;
  reg        pcm_fbit_i;
  reg  [7:0] pcm_data_i;
  reg  [4:0] pcm_chan_i;
  reg        sig_upd_i;
  reg  [4:0] sig_chan_i;
  reg  [3:0] sig_abcd_i;
  wire [7:0] addr_i;
  wire [7:0] wdata_i;
  wire       wr_i;
  wire       rd_i;
  wire [7:0] rdata_o;
  wire       pcm_valid_o;
  wire [7:0] pcm_data_o;
  wire       pcm_fbit_o;
  reg  [7:0] s0;
  reg  [7:0] s1;
  reg  [7:0] v;
  integer    fails;
  integer    comparisons;
  integer    cyc;
  integer    i;
  signalling_indirect_access DUT
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pcm_valid_i(pcm_valid_i),
    .pcm_data_i(pcm_data_i), .pcm_fbit_i(pcm_fbit_i), .pcm_chan_i(pcm_chan_i),
    .pcm_valid_o(pcm_valid_o), .pcm_data_o(pcm_data_o), .pcm_fbit_o(pcm_fbit_o),
    .sig_upd_i(sig_upd_i), .sig_chan_i(sig_chan_i), .sig_abcd_i(sig_abcd_i)
  );
  host_model HOST
  (
    .clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task check(input [7:0] seen, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task stop_test;
  begin
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      fails = fails + 1;
      stop_test;
    end
  end
  task sig(input [4:0] ch, input [3:0] d);
  begin
    @(posedge clk_i);
    sig_upd_i <= 1'b1;
    sig_chan_i <= ch;
    sig_abcd_i <= d;
    @(posedge clk_i);
    sig_upd_i <= 1'b0;
    sig_abcd_i <= ~d;
  end
  endtask
  task px(input [4:0] ch, input fb, input [7:0] e);
  begin
    @(posedge clk_i);
    pcm_valid_i <= 1'b1;
    pcm_chan_i <= ch;
    pcm_fbit_i <= fb;
    pcm_data_i <= 8'h5A;
    @(posedge clk_i);
    pcm_valid_i <= 1'b0;
    pcm_data_i <= 8'hA5;
    #1;
    check(pcm_data_o, e);
    check({pcm_valid_o, 6'h00, pcm_fbit_o}, {1'b1, 6'h00, fb});
  end
  endtask
  task t_regs;
  begin
    HOST.rd(8'h42, v);
    check(v, 8'h00);
    HOST.wr(8'h43, 8'hFF);
    HOST.rd(8'h43, v);
    check(v, 8'h0F);
    HOST.rd(8'h50, v);
    check(v, 8'h00);
    HOST.indirect(8'h21, 4'h3, s0, s1, v);
    check(s0, 8'h00);
    HOST.wr(8'h40, 8'h13);
    HOST.rd(8'h40, v);
    check(v, 8'h13);
    $display("regs test done");
  end
  endtask
  task t_index;
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      HOST.indirect((i == 0) ? 8'h21 : 8'h38, (i == 0) ? 4'h5 : 4'hA, s0, s1, v);
      check(s0, 8'h80);
      check(s1, 8'h00);
      HOST.indirect((i == 0) ? 8'hA1 : 8'hB8, 4'h0, s0, s1, v);
      check(v, (i == 0) ? 8'h05 : 8'h0A);
    end
    HOST.indirect(8'h99, 4'h0, s0, s1, v);
    check(s0, 8'h00);
    check(v, 8'h0A);
    HOST.indirect(8'h7F, 4'h3, s0, s1, v);
    check(s0, 8'h00);
    HOST.rd(8'h42, v);
    check(v, 8'h3F);
    $display("index test done");
  end
  endtask
  task t_sig;
  begin
    HOST.indirect(8'h22, 4'h1, s0, s1, v);
    for (i = 0; i < 6; i = i + 1)
    begin
      v = (i < 3) ? 8'h05 : ((i == 4) ? 8'h06 : 8'h09);
      sig(5'h02, v[3:0]);
      sig(5'h18, v[3:0]);
      if (i == 1)
      begin
        HOST.indirect(8'h98, 4'h0, s0, s1, v);
        check(v, 8'h00);
      end
    end
    HOST.indirect(8'h98, 4'h0, s0, s1, v);
    check(v, 8'h09);
    HOST.indirect(8'h82, 4'h0, s0, s1, v);
    check(v, 8'h05);
    HOST.indirect(8'hA2, 4'h0, s0, s1, v);
    check(v, 8'h01);
    HOST.wr(8'h40, 8'h03);
    HOST.indirect(8'h98, 4'h0, s0, s1, v);
    check(v, 8'h0A);
    $display("signalling test done");
  end
  endtask
  task t_pcm;
  begin
    HOST.indirect(8'h21, 4'hE, s0, s1, v);
    HOST.indirect(8'h23, 4'h6, s0, s1, v);
    px(5'h01, 1'b0, 8'hA4);
    px(5'h01, 1'b1, 8'h5A);
    px(5'h03, 1'b0, 8'h5B);
    // Extraction disabled also stops fixing
    HOST.wr(8'h40, 8'h07);
    px(5'h03, 1'b0, 8'h5A);
    HOST.wr(8'h40, 8'h02);
    px(5'h01, 1'b0, 8'h5A);
    $display("stream test done");
  end
  endtask
  initial
  begin
    fails = 0;
    comparisons = 0;
    cyc = 0;
    sys_rst_i = 1'b1;
    pcm_valid_i = 1'b0;
    pcm_fbit_i = 1'b0;
    pcm_data_i = 8'h00;
    pcm_chan_i = 5'h00;
    sig_upd_i = 1'b0;
    sig_chan_i = 5'h00;
    sig_abcd_i = 4'h0;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_index;
    t_sig;
    t_pcm;
    stop_test;
  end
endmodule
